//--- hdl/timer0_consts.svh
`ifndef TIMER0_CONSTS_SVH
`define TIMER0_CONSTS_SVH

// ----------------------------------------
// Register offsets on the I/O port
// ----------------------------------------
`define ADDR_CMP_B 6'h28
`define ADDR_CMP_A 6'h29
`define ADDR_CTRL_A 6'h2A
`define ADDR_GEN_CTRL 6'h2C
`define ADDR_COUNTER 6'h32
`define ADDR_CTRL_B 6'h33
`define ADDR_IRQ_STAT 6'h38
`define ADDR_IRQ_MASK 6'h39

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SYNC_HOLD_BIT 7
`define PSC_RESET_BIT 0
`define FLAG_OVF_BIT 0
`define FLAG_MATCH_B_BIT 1
`define FLAG_MATCH_A_BIT 2

// ----------------------------------------
// Reset values and count limits
// ----------------------------------------
`define RST_BYTE 8'h00
`define RST_FLAGS 3'h0
`define COUNT_MAX 8'hFF
`define COUNT_BOTTOM 8'h00
`define PRESC_WIDTH 10

`endif

//--- hdl/timer0_pkg.sv
package timer0_pkg;

    // Waveform generation modes
    typedef enum logic [2:0] {
        WM_NORMAL = 3'h0,
        WM_PHASE_FF = 3'h1,
        WM_CTC = 3'h2,
        WM_FAST_FF = 3'h3,
        WM_RSVD4 = 3'h4,
        WM_PHASE_OCA = 3'h5,
        WM_RSVD6 = 3'h6,
        WM_FAST_OCA = 3'h7
    } wave_mode_e;

    // Compare output actions
    typedef enum logic [1:0] {
        ACT_OFF = 2'h0,
        ACT_TOGGLE = 2'h1,
        ACT_CLEAR = 2'h2,
        ACT_SET = 2'h3
    } out_action_e;

    // Count direction of the dual-slope sequence
    typedef enum logic {
        DIR_UP = 1'b0,
        DIR_DOWN = 1'b1
    } count_dir_e;

    typedef struct packed {
        out_action_e chan_a_output_action;
        out_action_e chan_b_output_action;
        logic [1:0] waveform_mode_field;
    } ctrl_a_s;

    typedef struct packed {
        logic waveform_mode_msb;
        logic [2:0] tick_source_select;
    } ctrl_b_s;

    typedef struct packed {
        logic match_a;
        logic match_b;
        logic overflow;
    } timer_events_s;

endpackage

//--- hdl/timer0_prescaler.sv
`timescale 1ns/100ps
`include "timer0_consts.svh"

module timer0_prescaler #(
    parameter int PRESC_W = `PRESC_WIDTH
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic presc_clear,
    input wire logic [2:0] tick_source_select,
    input wire logic ext_rise,
    input wire logic ext_fall,
    output logic timer_tick_enable
);

    logic [PRESC_W-1:0] presc_reg;

    // True when the low bits of the prescaler are all ones
    function automatic logic tap_hit(input logic [PRESC_W-1:0] cnt, input int bits);
        logic hit;
        hit = 1'b1;
        for (int i = 0; i < bits; i++) begin
            hit = hit & cnt[i];
        end
        return hit;
    endfunction

    // Free-running divider, held at zero during prescaler reset
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            presc_reg <= '0;
        end else if (presc_clear) begin
            presc_reg <= '0;
        end else begin
            presc_reg <= presc_reg + {{(PRESC_W-1){1'b0}}, 1'b1};
        end
    end

    // Tick source select; a held reset halts every source
    always_comb begin
        timer_tick_enable = 1'b0;
        if (!presc_clear) begin
            unique case (tick_source_select)
                3'h0: timer_tick_enable = 1'b0;
                3'h1: timer_tick_enable = 1'b1;
                3'h2: timer_tick_enable = tap_hit(presc_reg, 3);
                3'h3: timer_tick_enable = tap_hit(presc_reg, 6);
                3'h4: timer_tick_enable = tap_hit(presc_reg, 8);
                3'h5: timer_tick_enable = tap_hit(presc_reg, 10);
                3'h6: timer_tick_enable = ext_fall;
                3'h7: timer_tick_enable = ext_rise;
            endcase
        end
    end

endmodule

//--- hdl/timer0_waveform_control.sv
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`include "timer0_consts.svh"

// Behaviour
// [RULE_01] All counter logic runs on ref_clk and the timer tick is only a clock enable.
// [RULE_02] While sync hold mode is set, the written prescaler reset bit is kept and halts the count.
// [RULE_03] Writing sync hold mode to zero clears the prescaler reset bit and counting resumes.
// [RULE_04] Writing one to the prescaler reset bit resets the prescaler and clears itself unless held.
// [RULE_05] A nonzero output action field gives the pin to the wave output; software sets direction.
// [RULE_06] Normal and clear-on-match modes toggle, clear or set the output on a match.
// [RULE_07] Fast PWM clears on match and sets at bottom for 10, the reverse for 11; 01 is reserved.
// [RULE_08] Fast PWM with compare equal to top and upper action bit set ignores the match only.
// [RULE_09] Phase-correct PWM clears on up match and sets on down match for 10, reverse for 11.
// [RULE_10] Phase-correct PWM with compare equal to top ignores the match and acts at top.
// [RULE_11] The three-bit waveform mode selects count sequence and top source.
// [RULE_12] Compare values update per mode, and the overflow flag sets per mode.
// [RULE_13] Control A bits 3 and 2 ignore writes and read as zero.
// [RULE_14] The tick source select picks stopped, the I/O clock, four taps or the pin edges.
// [RULE_15] A counter write suppresses any compare match on the next tick.
// [RULE_16] Flags assert in the cycle after the tick in which the counter value occurs.
module timer0_waveform_control (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic ext_tick_pin,
    output logic wave_out_a,
    output logic wave_out_a_override,
    output logic wave_out_b,
    output logic wave_out_b_override,
    output logic irq
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    timer0_pkg::ctrl_a_s ctrl_a_reg;
    timer0_pkg::ctrl_b_s ctrl_b_reg;
    timer0_pkg::wave_mode_e mode;
    timer0_pkg::count_dir_e dir_reg;
    timer0_pkg::timer_events_s events;
    logic sync_hold_reg;
    logic psc_reset_reg;
    logic [7:0] counter_reg;
    logic [7:0] cmp_a_buf_reg;
    logic [7:0] cmp_b_buf_reg;
    logic [7:0] cmp_a_reg;
    logic [7:0] cmp_b_reg;
    logic block_reg;
    logic [2:0] status_reg;
    logic [2:0] mask_reg;
    logic out_a_reg;
    logic out_b_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic pin_last_reg;
    logic timer_tick_enable;
    logic [7:0] top_val;
    logic at_top;
    logic wrap;
    logic cmp_update;
    logic cnt_write;
    logic gen_write;
    logic fast;
    logic phase;

    // ----------------------------------------
    // Mode decoding
    // ----------------------------------------
    function automatic logic is_fast(input timer0_pkg::wave_mode_e m);
        return (m == timer0_pkg::WM_FAST_FF) || (m == timer0_pkg::WM_FAST_OCA);
    endfunction

    function automatic logic is_phase(input timer0_pkg::wave_mode_e m);
        return (m == timer0_pkg::WM_PHASE_FF) || (m == timer0_pkg::WM_PHASE_OCA);
    endfunction

    function automatic logic top_from_a(input timer0_pkg::wave_mode_e m);
        return (m == timer0_pkg::WM_CTC) || (m == timer0_pkg::WM_PHASE_OCA)
            || (m == timer0_pkg::WM_FAST_OCA);
    endfunction

    // Next level of one wave output
    function automatic logic wave_next(
        input logic cur,
        input timer0_pkg::out_action_e act,
        input logic f_mode,
        input logic p_mode,
        input logic hit,
        input logic edge_top,
        input logic down,
        input logic special
    );
        logic res;
        res = cur;
        if (!f_mode && !p_mode) begin
            if (hit) begin
                unique case (act)
                    timer0_pkg::ACT_OFF: res = cur;
                    timer0_pkg::ACT_TOGGLE: res = ~cur;
                    timer0_pkg::ACT_CLEAR: res = 1'b0;
                    timer0_pkg::ACT_SET: res = 1'b1;
                endcase
            end
        end else if (act[1]) begin
            if (hit && !special) begin
                res = (act == timer0_pkg::ACT_SET) ^ (p_mode & down);
            end
            if (edge_top && (f_mode || special)) begin
                res = (act == timer0_pkg::ACT_CLEAR);
            end
        end
        return res;
    endfunction

    // Mode, top source and key count points
    assign mode = timer0_pkg::wave_mode_e'({ctrl_b_reg.waveform_mode_msb,
                                            ctrl_a_reg.waveform_mode_field}); // RULE_11
    assign fast = is_fast(mode);
    assign phase = is_phase(mode);
    assign top_val = top_from_a(mode) ? cmp_a_reg : `COUNT_MAX; // RULE_11
    assign at_top = (counter_reg == top_val);
    assign wrap = timer_tick_enable && at_top;
    assign cnt_write = reg_write && (reg_addr == `ADDR_COUNTER);
    assign gen_write = reg_write && (reg_addr == `ADDR_GEN_CTRL);

    // ----------------------------------------
    // Tick source
    // ----------------------------------------
    // Pin synchroniser and edge history
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            pin_last_reg <= 1'b0;
        end else begin
            pin_meta_reg <= ext_tick_pin;
            pin_sync_reg <= pin_meta_reg;
            pin_last_reg <= pin_sync_reg;
        end
    end

    // Prescaler and source select
    timer0_prescaler i_timer0_prescaler (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .presc_clear(psc_reset_reg), // RULE_04
        .tick_source_select(ctrl_b_reg.tick_source_select), // RULE_14
        .ext_rise(pin_sync_reg & ~pin_last_reg),
        .ext_fall(~pin_sync_reg & pin_last_reg),
        .timer_tick_enable(timer_tick_enable)
    );

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    // Waveform and tick source fields
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_a_reg <= '0;
            ctrl_b_reg <= '0;
        end else begin
            if (reg_write && reg_addr == `ADDR_CTRL_A) begin
                ctrl_a_reg <= {reg_wdata[7:4], reg_wdata[1:0]}; // RULE_13
            end
            if (reg_write && reg_addr == `ADDR_CTRL_B) begin
                ctrl_b_reg <= reg_wdata[3:0];
            end
        end
    end

    // Sync hold mode and self-clearing prescaler reset
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sync_hold_reg <= 1'b0;
            psc_reset_reg <= 1'b0;
        end else if (gen_write) begin
            sync_hold_reg <= reg_wdata[`SYNC_HOLD_BIT];
            psc_reset_reg <= reg_wdata[`PSC_RESET_BIT]; // RULE_04
        end else if (!sync_hold_reg) begin
            psc_reset_reg <= 1'b0; // RULE_03 RULE_04
        end
    end

    // Compare buffers written by software
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cmp_a_buf_reg <= `RST_BYTE;
            cmp_b_buf_reg <= `RST_BYTE;
        end else begin
            if (reg_write && reg_addr == `ADDR_CMP_A) begin
                cmp_a_buf_reg <= reg_wdata;
            end
            if (reg_write && reg_addr == `ADDR_CMP_B) begin
                cmp_b_buf_reg <= reg_wdata;
            end
        end
    end

    // Buffered compare values take effect at the mode's update point
    assign cmp_update = (!fast && !phase) || (wrap && dir_reg == timer0_pkg::DIR_UP); // RULE_12

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cmp_a_reg <= `RST_BYTE;
            cmp_b_reg <= `RST_BYTE;
        end else if (cmp_update) begin
            cmp_a_reg <= cmp_a_buf_reg;
            cmp_b_reg <= cmp_b_buf_reg;
        end
    end

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    // Count sequence advanced only on a tick
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            counter_reg <= `COUNT_BOTTOM;
            dir_reg <= timer0_pkg::DIR_UP;
        end else if (cnt_write) begin
            counter_reg <= reg_wdata;
        end else if (timer_tick_enable) begin // RULE_01
            if (phase) begin
                if (dir_reg == timer0_pkg::DIR_UP && at_top) begin
                    counter_reg <= counter_reg - 8'h01;
                    dir_reg <= timer0_pkg::DIR_DOWN;
                end else if (dir_reg == timer0_pkg::DIR_DOWN && counter_reg == `COUNT_BOTTOM) begin
                    counter_reg <= counter_reg + 8'h01;
                    dir_reg <= timer0_pkg::DIR_UP;
                end else if (dir_reg == timer0_pkg::DIR_UP) begin
                    counter_reg <= counter_reg + 8'h01;
                end else begin
                    counter_reg <= counter_reg - 8'h01;
                end
            end else begin
                counter_reg <= at_top ? `COUNT_BOTTOM : counter_reg + 8'h01; // RULE_11
                dir_reg <= timer0_pkg::DIR_UP;
            end
        end
    end

    // Match blocking after a counter write
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            block_reg <= 1'b0;
        end else if (cnt_write) begin
            block_reg <= 1'b1; // RULE_15
        end else if (timer_tick_enable) begin
            block_reg <= 1'b0;
        end
    end

    // Events of this tick
    always_comb begin
        events.match_a = timer_tick_enable && !block_reg && counter_reg == cmp_a_reg; // RULE_15
        events.match_b = timer_tick_enable && !block_reg && counter_reg == cmp_b_reg;
        if (phase) begin
            events.overflow = timer_tick_enable && counter_reg == `COUNT_BOTTOM; // RULE_12
        end else if (mode == timer0_pkg::WM_FAST_OCA) begin
            events.overflow = wrap;
        end else begin
            events.overflow = timer_tick_enable && counter_reg == `COUNT_MAX;
        end
    end

    // ----------------------------------------
    // Wave outputs
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            out_a_reg <= 1'b0;
            out_b_reg <= 1'b0;
        end else begin
            out_a_reg <= wave_next(out_a_reg, ctrl_a_reg.chan_a_output_action, fast, phase,
                events.match_a, wrap, dir_reg == timer0_pkg::DIR_DOWN,
                cmp_a_reg == top_val); // RULE_06 RULE_07 RULE_08 RULE_09 RULE_10
            out_b_reg <= wave_next(out_b_reg, ctrl_a_reg.chan_b_output_action, fast, phase,
                events.match_b, wrap, dir_reg == timer0_pkg::DIR_DOWN,
                cmp_b_reg == top_val); // RULE_06 RULE_07 RULE_08 RULE_09 RULE_10
        end
    end

    assign wave_out_a = out_a_reg;
    assign wave_out_b = out_b_reg;
    assign wave_out_a_override = |ctrl_a_reg.chan_a_output_action; // RULE_05
    assign wave_out_b_override = |ctrl_a_reg.chan_b_output_action; // RULE_05

    // ----------------------------------------
    // Flags and interrupt
    // ----------------------------------------
    // Sticky flags; a new event wins over a write-one clear
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            status_reg <= `RST_FLAGS;
            mask_reg <= `RST_FLAGS;
        end else begin
            if (reg_write && reg_addr == `ADDR_IRQ_STAT) begin
                status_reg <= (status_reg & ~reg_wdata[2:0]) | events; // RULE_16
            end else begin
                status_reg <= status_reg | events; // RULE_16
            end
            if (reg_write && reg_addr == `ADDR_IRQ_MASK) begin
                mask_reg <= reg_wdata[2:0];
            end
        end
    end

    assign irq = |(status_reg & mask_reg);

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always_comb begin
        rdata_next = 8'h00;
        unique case (reg_addr)
            `ADDR_CTRL_A: rdata_next = {ctrl_a_reg[5:2], 2'b00, ctrl_a_reg[1:0]}; // RULE_13
            `ADDR_CTRL_B: rdata_next = {4'h0, ctrl_b_reg};
            `ADDR_GEN_CTRL: rdata_next = {sync_hold_reg, 6'h00, psc_reset_reg};
            `ADDR_COUNTER: rdata_next = counter_reg;
            `ADDR_CMP_A: rdata_next = cmp_a_buf_reg;
            `ADDR_CMP_B: rdata_next = cmp_b_buf_reg;
            `ADDR_IRQ_STAT: rdata_next = {5'h00, status_reg};
            `ADDR_IRQ_MASK: rdata_next = {5'h00, mask_reg};
            default: rdata_next = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= reg_read ? rdata_next : 8'h00;
        end
    end

    assign reg_rdata = rdata_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    property p_tick_enable;
        !psc_reset_reg && ctrl_b_reg.tick_source_select == 3'h1 |-> timer_tick_enable;
    endproperty
    a_tick_enable: assert property (p_tick_enable) else $error("tick missing"); // RULE_01

    property p_hold_keeps;
        sync_hold_reg && psc_reset_reg && !gen_write |=> psc_reset_reg && !timer_tick_enable;
    endproperty
    a_hold_keeps: assert property (p_hold_keeps) else $error("held reset lost"); // RULE_02

    property p_hold_release;
        gen_write && !reg_wdata[7] ##1 !gen_write |=> !psc_reset_reg;
    endproperty
    a_hold_release: assert property (p_hold_release) else $error("reset not cleared"); // RULE_03

    property p_auto_clear;
        !sync_hold_reg && psc_reset_reg && !gen_write |=> !psc_reset_reg;
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("reset not self clearing"); // RULE_04

    property p_override;
        reg_write && reg_addr == `ADDR_CTRL_A && reg_wdata[7:6] != 2'h0 |=> wave_out_a_override;
    endproperty
    a_override: assert property (p_override) else $error("no override"); // RULE_05

    property p_toggle;
        mode == timer0_pkg::WM_NORMAL && events.match_a
            && ctrl_a_reg.chan_a_output_action == timer0_pkg::ACT_TOGGLE
            |=> wave_out_a != $past(wave_out_a);
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle"); // RULE_06

    property p_fast_bottom;
        fast && wrap && ctrl_a_reg.chan_a_output_action == timer0_pkg::ACT_CLEAR |=> wave_out_a;
    endproperty
    a_fast_bottom: assert property (p_fast_bottom) else $error("no set at bottom"); // RULE_07 RULE_08

    property p_phase_up;
        phase && events.match_a && dir_reg == timer0_pkg::DIR_UP && cmp_a_reg != top_val
            && ctrl_a_reg.chan_a_output_action == timer0_pkg::ACT_CLEAR |=> !wave_out_a;
    endproperty
    a_phase_up: assert property (p_phase_up) else $error("no clear on up match"); // RULE_09

    property p_ctc_wrap;
        mode == timer0_pkg::WM_CTC && wrap && !cnt_write |=> counter_reg == `COUNT_BOTTOM;
    endproperty
    a_ctc_wrap: assert property (p_ctc_wrap) else $error("no clear at top"); // RULE_11

    property p_block;
        cnt_write ##1 timer_tick_enable |-> !events.match_a && !events.match_b;
    endproperty
    a_block: assert property (p_block) else $error("match not blocked"); // RULE_15

    property p_flag_next;
        timer_tick_enable && !block_reg && counter_reg == cmp_b_reg |=> status_reg[1];
    endproperty
    a_flag_next: assert property (p_flag_next) else $error("flag late"); // RULE_16

    c_fast_wrap: cover property (fast && wrap);
    c_phase_turn: cover property (phase && wrap ##1 dir_reg == timer0_pkg::DIR_DOWN);
    c_irq: cover property (irq);

endmodule

//--- testbench/timer0_waveform_control_test.sv
`timescale 1ns/100ps
`include "timer0_consts.svh"

module timer0_waveform_control_test;
logic ref_clk = 1'b0;
logic resetn = 1'b0;
logic reg_write = 1'b0;
logic reg_read = 1'b0;
logic ext_tick_pin = 1'b0;
logic [5:0] reg_addr = 6'h00;
logic [7:0] reg_wdata = 8'h00;
logic [7:0] reg_rdata;
logic [7:0] d;
logic wave_out_a, wave_out_a_override, wave_out_b, wave_out_b_override, irq;
int n_fail = 0;
int n_checks = 0;
localparam logic [5:0] ca = `ADDR_CTRL_A, cb = `ADDR_CTRL_B, gc = `ADDR_GEN_CTRL;
localparam logic [5:0] cm = `ADDR_CMP_A, cn = `ADDR_COUNTER, st = `ADDR_IRQ_STAT;
logic [7:0] t_st [5] = '{8'h3E, 8'h40, 8'h3E, 8'h3E, 8'hFC};
logic [7:0] t_ac [5] = '{8'hC0, 8'h80, 8'h80, 8'h40, 8'h70};
logic [7:0] t_fl [5] = '{8'h04, 8'h00, 8'h04, 8'h04, 8'h03};
logic t_wv [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};

timer0_waveform_control i_timer0_waveform_control (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .ext_tick_pin(ext_tick_pin),
    .wave_out_a(wave_out_a),
    .wave_out_a_override(wave_out_a_override),
    .wave_out_b(wave_out_b),
    .wave_out_b_override(wave_out_b_override),
    .irq(irq)
);

// ----------------------------------------
// Clock and bus tasks
// ----------------------------------------
initial begin
    forever #25 ref_clk = ~ref_clk;
end

task run(input int n);
    repeat (n) @(posedge ref_clk);
endtask

task wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_write <= 1'b0;
endtask

task rd(input logic [5:0] a);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
endtask

task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
        $display("[ERR] %s expected %h seen %h", s, e, g);
        n_fail++;
    end
endtask

task tally_and_finish;
    if (n_fail == 0 && n_checks > 0) begin
        $display("Test passed");
    end else begin
        $display("Test failed");
    end
    $finish;
endtask

// Watchdog against a hung sequence
initial begin
    run(20000);
    n_fail++;
    tally_and_finish;
end

// ----------------------------------------
// Test sequence
// ----------------------------------------
initial begin
    run(10);
    resetn <= 1'b1;
    rd(ca); chk("ctrl_a_rst", 8'h00, d);
    rd(gc); chk("gen_rst", 8'h00, d);
    rd(6'h3F); chk("unmapped", 8'h00, d);
    wr(ca, 8'hFF); rd(ca); chk("ctrl_a_rsv", 8'hF3, d);
    chk("ovr", 8'h03, {6'h00, wave_out_a_override, wave_out_b_override});
    wr(ca, 8'h00); run(1);
    chk("ovr_off", 8'h00, {6'h00, wave_out_a_override, wave_out_b_override});
    wr(gc, 8'h01); rd(gc); chk("psr_self_clr", 8'h00, d);
    wr(gc, 8'h81); rd(gc); chk("psr_hold", 8'h81, d);
    wr(cn, 8'h00); wr(cb, 8'h01); run(20);
    rd(cn); chk("halted", 8'h00, d);
    wr(gc, 8'h00); rd(gc); chk("psr_release", 8'h00, d);
    run(20); rd(cn); chk("resumed", 8'h01, {7'h00, d >= 8'h10 && d <= 8'h20});
    // Divide-by-8 tap and the external pin edges
    wr(cb, 8'h00); wr(cn, 8'h00); wr(cb, 8'h02); run(80); wr(cb, 8'h00);
    rd(cn); chk("tap8", 8'h01, {7'h00, d >= 8'h09 && d <= 8'h0B});
    for (int s = 6; s < 8; s++) begin
        wr(cn, 8'h00); wr(cb, 8'(s));
        repeat (5) begin
            ext_tick_pin <= 1'b1; run(5);
            ext_tick_pin <= 1'b0; run(5);
        end
        wr(cb, 8'h00); rd(cn); chk("ext_edges", 8'h05, d);
    end
    // Normal mode actions, counter write suppression, overflow at MAX
    wr(cm, 8'h40);
    for (int i = 0; i < 5; i++) begin
        wr(cb, 8'h00); wr(ca, t_ac[i]); wr(cn, t_st[i]); wr(st, 8'h07);
        wr(cb, 8'h01); run(10);
        rd(st); chk("status", t_fl[i], d);
        chk("wave_a", {7'h00, t_wv[i]}, {7'h00, wave_out_a});
        chk("wave_b", {7'h00, i == 4}, {7'h00, wave_out_b});
    end
    // Clear-on-match with TOP from compare A, interrupt masking
    wr(ca, 8'h42); wr(cm, 8'h10); run(300); wr(st, 8'h07); run(100);
    repeat (3) begin
        wr(cb, 8'h00); rd(cn); chk("ctc_top", 8'h01, {7'h00, d <= 8'h10});
        wr(cb, 8'h01); run(7);
    end
    rd(st); chk("ctc_flags", 8'h04, d & 8'h05);
    wr(`ADDR_IRQ_MASK, 8'h04); run(2); chk("irq_on", 8'h01, {7'h00, irq});
    wr(`ADDR_IRQ_MASK, 8'h00); run(1); chk("irq_masked", 8'h00, {7'h00, irq});
    wr(cb, 8'h00); wr(st, 8'h07); rd(st); chk("w1c", 8'h00, d);
    // Fast PWM (mode 3) and phase-correct PWM (mode 1), both polarities
    for (int m = 0; m < 2; m++) begin
        for (int k = 2; k < 4; k++) begin
            wr(ca, 8'(k << 6) | (m ? 8'h01 : 8'h03)); wr(cm, 8'h80); wr(cb, 8'h01);
            run(600);
            repeat (3) begin
                wr(cb, 8'h00); rd(cn);
                if (d inside {[8'h02:8'h7E], [8'h82:8'hFE]}) begin
                    chk("pwm_a", {7'h00, (d < 8'h80) ^ (k == 3)}, {7'h00, wave_out_a});
                end
                wr(cb, 8'h01); run(97);
            end
        end
    end
    tally_and_finish;
end
endmodule
